// ==== hdl/uart_fe_am.sv ====
// Operation
// [R1] missing stop bit sets frame error flag
// [R2] view select 1: bit 7 is frame error
// [R3] view select 0: bit 7 is mode_sel_hi
// [R4] frame error cleared only by software write
// [R5] address compare only while addr_match_enable set
// [R6] 9-bit modes: done only on given/broadcast address
// [R7] ninth bit 1 marks address, 0 data
// [R8] mode 1: needs valid stop and address match
// [R9] mode field selects shift, 8-bit, 9-bit modes
// [R10] given address: slave_addr masked by slave_addr_mask
// [R11] broadcast: OR of both, zeros don't-care
// [R12] reset clears slave_addr and slave_addr_mask
// [R13] mode 0 ignores addr_match_enable
// [R14] receive starts only while receive_enable set
// [R15] hardware sets done flags; software clears them
`timescale 1ns/1ps
module uart_fe_am
    import uart_fe_am_pkg::*;
#(
    parameter int unsigned BIT_CYCLES = BIT_CYCLES_DEF
) (
    input  wire logic                  CLK_SYS_I,
    input  wire logic                  RST_I,
    input  wire logic                  PSEL_I,
    input  wire logic                  PENABLE_I,
    input  wire logic                  PWRITE_I,
    input  wire logic [APB_ADDR_W-1:0] PADDR_I,
    input  wire logic [APB_DATA_W-1:0] PWDATA_I,
    output logic      [APB_DATA_W-1:0] PRDATA_O,
    output logic                       PREADY_O,
    output logic                       PSLVERR_O,
    input  wire logic                  RXD_I,
    output logic                       TXD_O,
    output logic                       IRQ_O
);

    localparam int unsigned CW = (BIT_CYCLES > 2) ? $clog2(BIT_CYCLES) : 2;
    localparam logic [CW-1:0] CNT_LAST = CW'(BIT_CYCLES - 1);
    localparam logic [CW-1:0] CNT_HALF = CW'(BIT_CYCLES / 2);
    localparam logic [2:0]    BIT_LAST = 3'(DATA_BITS - 1);

    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    serial_control_type ctrl_r;
    logic               frame_error_r;
    logic [7:0]         power_r;
    logic [7:0]         slave_addr_r;
    logic [7:0]         slave_mask_r;
    logic [7:0]         rx_buf_r;
    logic [IRQ_W-1:0]   irq_status_r;
    logic [IRQ_W-1:0]   irq_mask_r;
    logic [APB_DATA_W-1:0] prdata_r;

    apb_req_type        req;
    logic               setup;
    logic               access;
    logic               wr_en;
    logic               rd_done;
    logic               sel_pwr, sel_ctrl, sel_data, sel_sa, sel_sm, sel_st, sel_mk;
    logic               hit;
    logic               view_fe;
    mode_type           mode;
    serial_control_type ctrl_view;
    logic [7:0]         rd_mux;

    function automatic logic [APB_ADDR_W-1:0] byte_addr(input logic [7:0] idx);
        byte_addr = {2'b00, idx, 2'b00};
    endfunction : byte_addr

    assign req      = '{addr: PADDR_I, write: PWRITE_I, wdata: PWDATA_I[7:0]};
    assign setup    = PSEL_I & ~PENABLE_I;
    assign access   = PSEL_I & PENABLE_I;
    assign sel_pwr  = req.addr == byte_addr(IDX_POWER_CONTROL);
    assign sel_ctrl = req.addr == byte_addr(IDX_SERIAL_CONTROL);
    assign sel_data = req.addr == byte_addr(IDX_SERIAL_DATA);
    assign sel_sa   = req.addr == byte_addr(IDX_SLAVE_ADDR);
    assign sel_sm   = req.addr == byte_addr(IDX_SLAVE_ADDR_MASK);
    assign sel_st   = req.addr == byte_addr(IDX_IRQ_STATUS);
    assign sel_mk   = req.addr == byte_addr(IDX_IRQ_MASK);
    assign hit      = sel_pwr | sel_ctrl | sel_data | sel_sa | sel_sm | sel_st | sel_mk;
    assign wr_en    = access & req.write & hit;
    assign rd_done  = access & ~req.write & hit;
    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = access & ~hit;
    assign PRDATA_O  = prdata_r;

    assign view_fe = power_r[VIEW_SEL_BIT];
    assign mode    = mode_type'({ctrl_r.shared_bit7, ctrl_r.mode_sel_lo}); // [R9]

    always_comb begin
        ctrl_view = ctrl_r;
        ctrl_view.shared_bit7 = view_fe ? frame_error_r : ctrl_r.shared_bit7; // [R2] [R3]
    end

    always_comb begin
        rd_mux = 8'h00;
        case (1'b1)
            sel_pwr:  rd_mux = power_r;
            sel_ctrl: rd_mux = ctrl_view;
            sel_data: rd_mux = rx_buf_r;
            sel_sa:   rd_mux = slave_addr_r;
            sel_sm:   rd_mux = slave_mask_r;
            sel_st:   rd_mux = 8'(irq_status_r);
            sel_mk:   rd_mux = 8'(irq_mask_r);
            default:  rd_mux = 8'h00;
        endcase
    end

    // read data is captured in the setup cycle, so the access cycle answers at once
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            prdata_r <= '0;
        end else if (setup && !req.write) begin
            prdata_r <= {24'h000000, rd_mux};
        end
    end

    // ------------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------------
    rx_state_type rx_state_r;
    logic [CW-1:0] rx_cnt_r;
    logic [2:0]    rx_bit_r;
    logic [7:0]    rx_shift_r;
    logic          rx_ninth_r;
    logic          rx_tick;
    logic          rx_fin;
    logic          stop_ok;
    logic          given_hit;
    logic          bcast_hit;
    logic          filter;
    logic          accept;
    logic          fe_set;
    logic          rx_set;
    logic          nine_bit;

    assign nine_bit  = (mode == MODE_UART9_FIX) || (mode == MODE_UART9_VAR);
    assign rx_tick   = rx_cnt_r == CNT_LAST;
    assign rx_fin    = (rx_state_r == RX_STOP) && rx_tick;
    assign stop_ok   = RXD_I == STOP_LEVEL;
    assign given_hit = ((rx_shift_r ^ slave_addr_r) & slave_mask_r) == 8'h00; // [R10]
    assign bcast_hit = ((rx_shift_r ^ ALL_ONES) & (slave_addr_r | slave_mask_r)) == 8'h00; // [R11]
    assign filter    = ctrl_r.addr_match_enable && (mode != MODE_SHIFT); // [R5] [R13]

    always_comb begin
        if (!filter) begin
            accept = 1'b1;
        end else if (mode == MODE_UART8) begin
            accept = stop_ok && (given_hit || bcast_hit); // [R8]
        end else begin
            accept = (rx_ninth_r == ADDR_MARK) && (given_hit || bcast_hit); // [R6] [R7]
        end
    end

    // the shift mode has no stop bit to check
    assign fe_set = rx_fin && !stop_ok && (mode != MODE_SHIFT); // [R1]
    assign rx_set = rx_fin && accept;

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            rx_state_r <= RX_IDLE;
            rx_cnt_r   <= '0;
            rx_bit_r   <= '0;
            rx_shift_r <= 8'h00;
            rx_ninth_r <= 1'b0;
        end else begin
            rx_cnt_r <= rx_tick ? '0 : rx_cnt_r + CW'(1);
            case (rx_state_r)
                RX_IDLE: begin
                    rx_cnt_r <= '0;
                    if (ctrl_r.receive_enable && RXD_I == START_LEVEL) begin // [R14]
                        rx_state_r <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_cnt_r == CNT_HALF) begin
                        rx_cnt_r   <= '0;
                        rx_bit_r   <= '0;
                        rx_state_r <= (RXD_I == START_LEVEL) ? RX_DATA : RX_IDLE;
                    end
                end
                RX_DATA: begin
                    if (rx_tick) begin
                        rx_shift_r <= {RXD_I, rx_shift_r[7:1]};
                        rx_bit_r   <= rx_bit_r + 3'd1;
                        if (rx_bit_r == BIT_LAST) begin
                            rx_state_r <= nine_bit ? RX_NINTH : RX_STOP; // [R9]
                        end
                    end
                end
                RX_NINTH: begin
                    if (rx_tick) begin
                        rx_ninth_r <= RXD_I; // [R7]
                        rx_state_r <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_tick) begin
                        rx_state_r <= RX_IDLE;
                    end
                end
                default: rx_state_r <= RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            rx_buf_r <= 8'h00;
        end else if (rx_set) begin
            rx_buf_r <= rx_shift_r;
        end
    end

    // ------------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------------
    tx_state_type tx_state_r;
    logic [CW-1:0] tx_cnt_r;
    logic [2:0]    tx_bit_r;
    logic [7:0]    tx_shift_r;
    logic          txd_r;
    logic          tx_tick;
    logic          tx_start;
    logic          tx_set;

    assign tx_tick  = tx_cnt_r == CNT_LAST;
    // a write while busy is dropped; software waits for tx_done_flag
    assign tx_start = wr_en && sel_data && (tx_state_r == TX_IDLE);
    assign tx_set   = tx_tick && (tx_state_r == TX_STOP);
    assign TXD_O    = txd_r;

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            tx_state_r <= TX_IDLE;
            tx_cnt_r   <= '0;
            tx_bit_r   <= '0;
            tx_shift_r <= 8'h00;
            txd_r      <= 1'b1;
        end else begin
            tx_cnt_r <= (tx_tick || tx_state_r == TX_IDLE) ? '0 : tx_cnt_r + CW'(1);
            case (tx_state_r)
                TX_IDLE: begin
                    txd_r <= STOP_LEVEL;
                    if (tx_start) begin
                        tx_shift_r <= req.wdata;
                        txd_r      <= START_LEVEL;
                        tx_state_r <= TX_START;
                    end
                end
                TX_START: begin
                    if (tx_tick) begin
                        txd_r      <= tx_shift_r[0];
                        tx_shift_r <= {1'b0, tx_shift_r[7:1]};
                        tx_bit_r   <= '0;
                        tx_state_r <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (tx_tick) begin
                        tx_bit_r   <= tx_bit_r + 3'd1;
                        txd_r      <= tx_shift_r[0];
                        tx_shift_r <= {1'b0, tx_shift_r[7:1]};
                        if (tx_bit_r == BIT_LAST) begin
                            txd_r      <= nine_bit ? ctrl_r.tx_ninth_bit : STOP_LEVEL; // [R9]
                            tx_state_r <= nine_bit ? TX_NINTH : TX_STOP;
                        end
                    end
                end
                TX_NINTH: begin
                    if (tx_tick) begin
                        txd_r      <= STOP_LEVEL;
                        tx_state_r <= TX_STOP;
                    end
                end
                TX_STOP: begin
                    if (tx_tick) begin
                        tx_state_r <= TX_IDLE;
                    end
                end
                default: tx_state_r <= TX_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // control registers; a hardware set always wins over a software clear
    // ------------------------------------------------------------------
    logic ctrl_wr;

    assign ctrl_wr = wr_en && sel_ctrl;

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            ctrl_r <= serial_control_type'(RST_BYTE);
        end else begin
            if (ctrl_wr) begin
                ctrl_r <= serial_control_type'(req.wdata);
                if (view_fe) begin
                    ctrl_r.shared_bit7 <= ctrl_r.shared_bit7; // [R2]
                end
            end
            if (rx_set) begin
                ctrl_r.rx_done_flag <= 1'b1; // [R15]
                if (mode == MODE_UART8 || nine_bit) begin
                    ctrl_r.rx_ninth_bit <= nine_bit ? rx_ninth_r : stop_ok;
                end
            end
            if (tx_set) begin
                ctrl_r.tx_done_flag <= 1'b1; // [R15]
            end
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            frame_error_r <= 1'b0;
        end else if (fe_set) begin
            frame_error_r <= 1'b1; // [R1]
        end else if (ctrl_wr && view_fe) begin
            frame_error_r <= req.wdata[7]; // [R4]
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            power_r      <= RST_BYTE;
            slave_addr_r <= RST_BYTE; // [R12]
            slave_mask_r <= RST_BYTE; // [R12]
            irq_mask_r   <= '0;
        end else if (wr_en) begin
            if (sel_pwr) power_r      <= req.wdata;
            if (sel_sa)  slave_addr_r <= req.wdata;
            if (sel_sm)  slave_mask_r <= req.wdata;
            if (sel_mk)  irq_mask_r   <= req.wdata[IRQ_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // interrupt: only bits that the read returned are cleared
    // ------------------------------------------------------------------
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;

    always_comb begin
        irq_set = '0;
        irq_set[IRQ_RX_BIT] = rx_set;
        irq_set[IRQ_TX_BIT] = tx_set;
        irq_set[IRQ_FE_BIT] = fe_set;
    end

    assign irq_clr = (rd_done && sel_st) ? prdata_r[IRQ_W-1:0] : '0;

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            irq_status_r <= '0;
        end else begin
            irq_status_r <= (irq_status_r & ~irq_clr) | irq_set;
        end
    end

    assign IRQ_O = |(irq_status_r & irq_mask_r);

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_fe_set;
        fe_set |=> frame_error_r;
    endproperty
    a_fe_set: assert property (p_fe_set) else $error("frame error not recorded"); // [R1]

    property p_view_fe;
        setup && !req.write && sel_ctrl && view_fe |=> prdata_r[7] == $past(frame_error_r);
    endproperty
    a_view_fe: assert property (p_view_fe) else $error("bit 7 not frame error"); // [R2]

    property p_view_mode;
        setup && !req.write && sel_ctrl && !view_fe
            |=> prdata_r[7] == $past(ctrl_r.shared_bit7);
    endproperty
    a_view_mode: assert property (p_view_mode) else $error("bit 7 not mode bit"); // [R3]

    property p_fe_sticky;
        frame_error_r && !(ctrl_wr && view_fe) |=> frame_error_r;
    endproperty
    a_fe_sticky: assert property (p_fe_sticky) else $error("frame error lost"); // [R4]

    property p_no_filter;
        rx_fin && !filter |=> ctrl_r.rx_done_flag && irq_status_r[IRQ_RX_BIT];
    endproperty
    a_no_filter: assert property (p_no_filter) else $error("unfiltered frame dropped"); // [R5]

    property p_filter9;
        rx_fin && filter && nine_bit && (rx_ninth_r != ADDR_MARK || !(given_hit || bcast_hit))
            && !ctrl_r.rx_done_flag && !ctrl_wr |=> !ctrl_r.rx_done_flag;
    endproperty
    a_filter9: assert property (p_filter9) else $error("9-bit filter leaked"); // [R6]

    property p_filter8;
        rx_fin && filter && mode == MODE_UART8 && !(stop_ok && (given_hit || bcast_hit))
            && !ctrl_r.rx_done_flag && !ctrl_wr |=> !ctrl_r.rx_done_flag;
    endproperty
    a_filter8: assert property (p_filter8) else $error("8-bit filter leaked"); // [R8]

    property p_ninth_path;
        rx_state_r == RX_DATA && rx_tick && rx_bit_r == BIT_LAST && nine_bit
            |=> rx_state_r == RX_NINTH ##BIT_CYCLES rx_state_r == RX_STOP;
    endproperty
    a_ninth_path: assert property (p_ninth_path) else $error("ninth bit skipped"); // [R9]

    property p_rx_enable;
        rx_state_r == RX_IDLE && !ctrl_r.receive_enable |=> rx_state_r == RX_IDLE;
    endproperty
    a_rx_enable: assert property (p_rx_enable) else $error("reception while disabled"); // [R14]

    property p_tx_done;
        tx_start |=> ##1 !$rose(ctrl_r.tx_done_flag);
    endproperty
    a_tx_done: assert property (p_tx_done) else $error("tx done too early"); // [R15]

    property p_addr_reset;
        @(posedge CLK_SYS_I) disable iff (1'b0)
            RST_I |=> slave_addr_r == 8'h00 && slave_mask_r == 8'h00;
    endproperty
    a_addr_reset: assert property (p_addr_reset) else $error("address not cleared"); // [R12]

    c_frame_error: cover property (fe_set);
    c_addr_accept: cover property (rx_fin && filter && accept);
    c_broadcast:   cover property (rx_fin && filter && bcast_hit && !given_hit);
    c_tx_done:     cover property (tx_set);

endmodule : uart_fe_am

// ==== inc/uart_fe_am_pkg.sv ====
package uart_fe_am_pkg;

    // ------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam int unsigned APB_ADDR_W           = 12;
    localparam int unsigned APB_DATA_W           = 32;
    localparam logic [7:0]  IDX_POWER_CONTROL    = 8'h87;
    localparam logic [7:0]  IDX_SERIAL_CONTROL   = 8'h98;
    localparam logic [7:0]  IDX_SERIAL_DATA      = 8'h99;
    localparam logic [7:0]  IDX_SLAVE_ADDR       = 8'hA9;
    localparam logic [7:0]  IDX_SLAVE_ADDR_MASK  = 8'hB9;
    localparam logic [7:0]  IDX_IRQ_STATUS       = 8'hC0;
    localparam logic [7:0]  IDX_IRQ_MASK         = 8'hC1;

    // ------------------------------------------------------------------
    // reset values and field positions
    // ------------------------------------------------------------------
    localparam logic [7:0]  RST_BYTE             = 8'h00;
    localparam int unsigned VIEW_SEL_BIT         = 6;
    localparam int unsigned IRQ_W                = 3;
    localparam int unsigned IRQ_RX_BIT           = 0;
    localparam int unsigned IRQ_TX_BIT           = 1;
    localparam int unsigned IRQ_FE_BIT           = 2;
    localparam logic        STOP_LEVEL           = 1'b1;
    localparam logic        START_LEVEL          = 1'b0;
    localparam logic        ADDR_MARK            = 1'b1;
    localparam logic [7:0]  ALL_ONES             = 8'hFF;
    localparam int unsigned DATA_BITS            = 8;
    localparam int unsigned BIT_CYCLES_DEF       = 16;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_SHIFT, MODE_UART8, MODE_UART9_FIX, MODE_UART9_VAR
    } mode_type;

    typedef struct packed {
        logic shared_bit7;
        logic mode_sel_lo;
        logic addr_match_enable;
        logic receive_enable;
        logic tx_ninth_bit;
        logic rx_ninth_bit;
        logic tx_done_flag;
        logic rx_done_flag;
    } serial_control_type;

    typedef struct packed {
        logic [APB_ADDR_W-1:0] addr;
        logic                  write;
        logic [7:0]            wdata;
    } apb_req_type;

    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP} rx_state_type;
    typedef enum {TX_IDLE, TX_START, TX_DATA, TX_NINTH, TX_STOP} tx_state_type;

endpackage : uart_fe_am_pkg

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench
    import uart_fe_am_pkg::*;
();
    // short bit time keeps the run small; the peer bit time and the line-sampling waits derive from it
    localparam int unsigned BC = 4;
    logic        clk_sys = 1'b0;
    logic        rst     = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h00000000;
    logic        go      = 1'b0;
    logic [7:0]  pdata   = 8'h00;
    logic        pnine   = 1'b0;
    logic        pninth  = 1'b0;
    logic        pstop   = 1'b1;
    logic [31:0] prdata;
    logic        pready, pslverr, rxd, txd, irq, pbusy, err, nb, st, ex;
    logic [7:0]  rd, sa, sm, b;
    logic [9:0]  tx;
    int          n_fail  = 0;
    int          n_tests = 0;
    logic [7:0]  regs [6] = '{IDX_POWER_CONTROL, IDX_SERIAL_CONTROL, IDX_SLAVE_ADDR,
                              IDX_SLAVE_ADDR_MASK, IDX_IRQ_STATUS, IDX_IRQ_MASK};

    always #50 clk_sys = ~clk_sys;

    uart_fe_am #(.BIT_CYCLES(BC)) i_uart_fe_am (
        .CLK_SYS_I(clk_sys), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .RXD_I(rxd), .TXD_O(txd), .IRQ_O(irq)
    );
    uart_peer #(.BIT_CYCLES(BC)) i_uart_peer (
        .clk_i(clk_sys), .go_i(go), .data_i(pdata), .nine_i(pnine),
        .ninth_i(pninth), .stop_i(pstop), .line_o(rxd), .busy_o(pbusy)
    );

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected byte at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk_byte

    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected bit at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk_bit

    // irq is combinational of registers: look after the edge has landed
    task automatic chk_irq(input logic exp);
        @(negedge clk_sys);
        chk_bit(irq, exp);
    endtask : chk_irq

    task automatic apb(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h000000, wd};
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rd      = prdata[7:0];
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic send(input logic [7:0] d, input logic n9, input logic b9, input logic s);
        @(posedge clk_sys);
        go     <= 1'b1;
        pdata  <= d;
        pnine  <= n9;
        pninth <= b9;
        pstop  <= s;
        @(posedge clk_sys);
        go <= 1'b0;
        @(posedge clk_sys);
        while (pbusy !== 1'b0) @(posedge clk_sys);
        repeat (2) @(posedge clk_sys);
    endtask : send

    function automatic logic accept(input logic [1:0] m, input logic am, input logic [7:0] d,
                                    input logic n9, input logic s, input logic [7:0] a,
                                    input logic [7:0] k);
        logic hit;
        hit = (((d ^ a) & k) == 8'h00) || ((d & (a | k)) == (a | k));
        if (m == 2'b00 || !am) return 1'b1;
        if (m == 2'b01) return s && hit;
        return n9 && hit;
    endfunction : accept

    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        end_sim();
    end

    initial begin
        void'($urandom(32'hA64DA734));
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (regs[i]) begin
            apb(regs[i], 1'b0, 8'h00);
            chk_byte(rd, RST_BYTE);
        end
        apb(8'h10, 1'b0, 8'h00);
        chk_bit(err, 1'b1);
        chk_byte(rd, 8'h00);
        // receiver off: frames must leave every mode's control byte untouched
        for (int m = 0; m < 4; m++) begin
            apb(IDX_SERIAL_CONTROL, 1'b1, {m[1:0], 6'h00});
            send(8'h5A, m[1], 1'b1, 1'b1);
            apb(IDX_SERIAL_CONTROL, 1'b0, 8'h00);
            chk_byte(rd, {m[1:0], 6'h00});
        end
        // mode_sel_hi is only writable while bit 7 shows the mode, so set mode 1 first
        apb(IDX_SERIAL_CONTROL, 1'b1, 8'h50);
        apb(IDX_POWER_CONTROL, 1'b1, 8'h40);
        send(8'h3C, 1'b0, 1'b0, 1'b0);
        apb(IDX_SERIAL_CONTROL, 1'b0, 8'h00);
        chk_byte(rd, 8'hD1);
        chk_irq(1'b0);
        apb(IDX_IRQ_MASK, 1'b1, 8'h04);
        chk_irq(1'b1);
        apb(IDX_IRQ_STATUS, 1'b0, 8'h00);
        chk_byte(rd, 8'h05);
        chk_irq(1'b0);
        apb(IDX_SERIAL_CONTROL, 1'b1, 8'hD0);
        send(8'hC3, 1'b0, 1'b0, 1'b1);
        apb(IDX_SERIAL_CONTROL, 1'b0, 8'h00);
        chk_byte(rd, 8'hD5);
        apb(IDX_POWER_CONTROL, 1'b1, 8'h00);
        apb(IDX_SERIAL_CONTROL, 1'b0, 8'h00);
        chk_byte(rd, 8'h55);
        apb(IDX_POWER_CONTROL, 1'b1, 8'h40);
        apb(IDX_SERIAL_CONTROL, 1'b1, 8'h50);
        apb(IDX_SERIAL_CONTROL, 1'b0, 8'h00);
        chk_byte(rd, 8'h50);
        apb(IDX_POWER_CONTROL, 1'b1, 8'h00);
        apb(IDX_IRQ_MASK, 1'b1, 8'h01);
        apb(IDX_IRQ_STATUS, 1'b0, 8'h00);
        for (int m = 0; m < 4; m++) begin
            for (int am = 0; am < 2; am++) begin
                sa = 8'($urandom);
                sm = 8'($urandom);
                apb(IDX_SLAVE_ADDR, 1'b1, sa);
                apb(IDX_SLAVE_ADDR_MASK, 1'b1, sm);
                for (int k = 0; k < 6; k++) begin
                    b  = (k == 0) ? sa : (k == 1) ? ALL_ONES : 8'($urandom);
                    nb = (k < 2) ? ADDR_MARK : 1'($urandom);
                    st = (m == 1 && k > 2) ? 1'($urandom) : STOP_LEVEL;
                    ex = accept(m[1:0], am[0], b, nb, st, sa, sm);
                    apb(IDX_SERIAL_CONTROL, 1'b1, {m[1:0], am[0], 5'h10});
                    send(b, m[1], nb, st);
                    apb(IDX_SERIAL_CONTROL, 1'b0, 8'h00);
                    chk_bit(rd[0], ex);
                    if (ex && m != 0) chk_bit(rd[2], m[1] ? nb : st);
                    chk_irq(ex);
                    apb(IDX_IRQ_STATUS, 1'b0, 8'h00);
                    chk_bit(rd[IRQ_RX_BIT], ex);
                    apb(IDX_SERIAL_DATA, 1'b0, 8'h00);
                    if (ex) chk_byte(rd, b);
                end
            end
        end
        apb(IDX_SERIAL_CONTROL, 1'b1, 8'hD8);
        b = 8'($urandom);
        apb(IDX_SERIAL_DATA, 1'b1, b);
        while (txd !== START_LEVEL) @(posedge clk_sys);
        repeat (BC / 2) @(posedge clk_sys);
        for (int i = 0; i < 10; i++) begin
            repeat (BC) @(posedge clk_sys);
            tx[i] = txd;
        end
        chk_byte(tx[7:0], b);
        chk_bit(tx[8], 1'b1);
        chk_bit(tx[9], STOP_LEVEL);
        repeat (BC) @(posedge clk_sys);
        apb(IDX_SERIAL_CONTROL, 1'b0, 8'h00);
        chk_bit(rd[1], 1'b1);
        apb(IDX_IRQ_STATUS, 1'b0, 8'h00);
        chk_bit(rd[IRQ_TX_BIT], 1'b1);
        end_sim();
    end
endmodule : testbench

// ==== tb/uart_peer.sv ====
`timescale 1ns/1ps
module uart_peer
    import uart_fe_am_pkg::*;
#(
    parameter int unsigned BIT_CYCLES = 4
) (
    input  wire logic       clk_i,
    input  wire logic       go_i,
    input  wire logic [7:0] data_i,
    input  wire logic       nine_i,
    input  wire logic       ninth_i,
    input  wire logic       stop_i,
    output logic            line_o,
    output logic            busy_o
);
    logic [9:0] frm_r;
    int         n_r;
    int         c_r;

    // line rests at the stop level between frames, like a real idle mark
    initial begin
        line_o = STOP_LEVEL;
        busy_o = 1'b0;
    end

    always @(posedge clk_i) begin
        if (!busy_o && go_i) begin
            frm_r  <= nine_i ? {stop_i, ninth_i, data_i} : {1'b1, stop_i, data_i};
            n_r    <= nine_i ? 10 : 9;
            c_r    <= 1;
            busy_o <= 1'b1;
            line_o <= START_LEVEL;
        end else if (busy_o && c_r == BIT_CYCLES) begin
            line_o <= (n_r == 0) ? STOP_LEVEL : frm_r[0];
            frm_r  <= frm_r >> 1;
            n_r    <= n_r - 1;
            c_r    <= 1;
            busy_o <= (n_r != 0);
        end else if (busy_o) begin
            c_r <= c_r + 1;
        end
    end
endmodule : uart_peer
